// ===== dcc_defs.svh
/*
  Register indices, field positions and reset values of the converter
  clamp, calibration and status register slice.
  Assumes an Avalon-MM byte address, with the register index in bits 7:2.
*/
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH

// Register indices, byte address is four times the index
`define DCC_IDX_BB_CFG 6'h07
`define DCC_IDX_CAL_EN 6'h08
`define DCC_IDX_GAIN 6'h09
`define DCC_IDX_OFFS 6'h0A
`define DCC_IDX_STATUS 6'h0B
`define DCC_IDX_IRQ_STAT 6'h10
`define DCC_IDX_IRQ_EN 6'h11
`define DCC_IDX_IRQ_CLR 6'h12

// Buck-boost configuration fields
`define DCC_NCLAMP_HI 5
`define DCC_NCLAMP_LO 2
`define DCC_ARM_HI 1
`define DCC_ARM_LO 0
`define DCC_BB_CFG_RST 6'h00
`define DCC_ARM_OFF 2'h0
`define DCC_ARM_POS 2'h1
`define DCC_ARM_NEG 2'h2

// Negative clamp codes valid in voltage output mode
`define DCC_NCL_V9 4'h2
`define DCC_NCL_V15 4'h7
`define DCC_NCL_V18 4'h9
`define DCC_NCL_LAST 4'h9

// Status register
`define DCC_STATUS_RST 16'h1000
`define DCC_ST_LEARN 12
`define DCC_ST_WDT 11
`define DCC_ST_PG 7
`define DCC_ST_TGL 6
`define DCC_ST_CRC 5
`define DCC_ST_TMP 4
`define DCC_ST_FAULT 0
`define DCC_STATUS_WMASK 16'h1831

// Synchronised pin vector positions
`define DCC_PIN_VMODE 0
`define DCC_PIN_LEARN 1
`define DCC_PIN_WDT 2
`define DCC_PIN_CRC 3
`define DCC_PIN_TMP 4
`define DCC_PIN_FAULT 5
`define DCC_PIN_PG 6
`define DCC_PIN_TGL 7

// Interrupt status bits
`define DCC_IRQ_LEARN 0
`define DCC_IRQ_WDT 1
`define DCC_IRQ_CRC 2
`define DCC_IRQ_TMP 3
`define DCC_IRQ_FAULT 4
`define DCC_IRQ_PG 5
`define DCC_IRQ_BADCL 6

`endif

// ===== dcc_pkg.sv
/*
  State types of the clamp, calibration and status register slice.
  Assumes dcc_defs.svh for the register indices, field positions and reset values.
*/
package dcc_pkg;

  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] prev;
    logic [5:0] bb_cfg;
    logic cal_on;
    logic [15:0] gain;
    logic [15:0] offs;
    logic [15:0] status;
    logic [6:0] irq_stat;
    logic [6:0] irq_en;
    logic ack;
    logic [31:0] rdata;
    logic [4:0] clamp_volts;
    logic clamp_bad;
  } dcc_regs_st_t;

  typedef struct packed {
    logic [15:0] code;
    logic vld;
  } dcc_cal_st_t;

endpackage : dcc_pkg

// ===== dcc_cal.sv
/*
  Calibration stage: applies user gain and offset to each input code.
  Assumes code, valid and settings come from logic on the same clock.
*/
`timescale 1ns/10ps
`include "dcc_defs.svh"

module dcc_cal (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cal_on,
  input wire logic [15:0] gain,
  input wire logic [15:0] offs,
  input wire logic [15:0] code_in,
  input wire logic code_in_valid,
  output logic [15:0] code_out,
  output logic code_out_valid
);

  dcc_pkg::dcc_cal_st_t st_ff;
  dcc_pkg::dcc_cal_st_t nxt_st;
  logic signed [32:0] prod;
  logic signed [18:0] sum;

  // Gain is a signed fraction of full scale, offset a signed code step
  always_comb begin
    nxt_st = st_ff;
    prod = $signed({1'b0, code_in}) * $signed(gain);
    sum = $signed({3'b000, code_in}) + $signed(prod[32:16]) +
          $signed({{3{offs[15]}}, offs});
    nxt_st.vld = code_in_valid;
    if (code_in_valid) begin
      if (!cal_on) begin
        nxt_st.code = code_in;
      end else if (sum[18]) begin
        nxt_st.code = 16'h0000;
      end else if (sum[17:16] != 2'h0) begin
        // Saturate rather than wrap past full scale
        nxt_st.code = 16'hFFFF;
      end else begin
        nxt_st.code = sum[15:0]; // see [R11]
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign code_out = st_ff.code;
  assign code_out_valid = st_ff.vld;

endmodule : dcc_cal

// ===== dcc_regs.sv
/*
  Clamp, arm select, calibration and status registers behind an
  Avalon-MM slave with waitrequest, plus the calibration data path.
  Assumes status and mode pins are asynchronous and input codes arrive
  on clk.
*/
// Operation
// [R1] Negative clamp bits 5:2 reset zero; codes map -5 V to -18 V.
// [R2] Voltage mode accepts only codes 2, 7, 9; 101x and 11xx never valid.
// [R3] Arm select bits 1:0 reset 00, both arms off.
// [R4] Arm select 01 enables positive arm only.
// [R5] Arm select 10 enables negative arm only.
// [R6] Calibration enable at 0x08 bit 0, resets off; rest reserved.
// [R7] User gain at 0x09, 16-bit read/write, resets zero.
// [R8] User offset at 0x0A, 16-bit read/write, resets zero.
// [R9] Status at 0x0B resets 0x1000; other flags start zero.
// [R10] Status bit 12 set when automatic learning finishes.
// [R11] Calibration on applies gain and offset to each input code.
`timescale 1ns/10ps
`include "dcc_defs.svh"

module dcc_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic voltage_mode,
  input wire logic learning_done,
  input wire logic watchdog_fault,
  input wire logic crc_error,
  input wire logic overheat,
  input wire logic dac_fault,
  input wire logic converter_power_good,
  input wire logic user_toggle,
  input wire logic [15:0] code_in,
  input wire logic code_in_valid,
  output logic [15:0] code_out,
  output logic code_out_valid,
  output logic pos_arm_en,
  output logic neg_arm_en,
  output logic [3:0] negative_clamp_select,
  output logic [4:0] neg_clamp_volts,
  output logic clamp_code_invalid,
  output logic irq
);

  dcc_pkg::dcc_regs_st_t st_ff;
  dcc_pkg::dcc_regs_st_t nxt_st;

  logic [7:0] pins;
  logic [5:0] idx;
  logic req;
  logic commit;
  logic wr;
  logic [6:0] events;
  logic [15:0] hw_set;
  logic [15:0] rd16;
  logic [3:0] ncl;
  logic [1:0] arm;

  // Merge a write into a 16-bit register by byte lane
  function automatic logic [15:0] dcc_merge(
    input logic [15:0] old_val,
    input logic [31:0] wdata,
    input logic [3:0] be
  );
    logic [15:0] res;
    res = old_val;
    if (be[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction : dcc_merge

  // Clamp magnitude in volts, zero where the code is not usable
  function automatic logic [4:0] dcc_clamp_volts(
    input logic [3:0] code,
    input logic vmode
  );
    logic [4:0] v;
    v = 5'h00;
    unique case (code)
      4'h0: v = 5'h05;
      4'h1: v = 5'h06;
      4'h2: v = 5'h09;
      4'h3: v = 5'h0B;
      4'h4: v = 5'h0C;
      4'h5: v = 5'h0D;
      4'h6: v = 5'h0E;
      4'h7: v = 5'h0F;
      4'h8: v = 5'h12;
      4'h9: v = 5'h12;
      default: v = 5'h00;
    endcase
    // Voltage mode keeps only three of the current mode settings
    if (vmode && code != `DCC_NCL_V9 && code != `DCC_NCL_V15 &&
        code != `DCC_NCL_V18) begin
      v = 5'h00;
    end
    return v;
  endfunction : dcc_clamp_volts

  function automatic logic dcc_clamp_bad(
    input logic [3:0] code,
    input logic vmode
  );
    logic bad;
    bad = code > `DCC_NCL_LAST;
    if (vmode) begin
      bad = code != `DCC_NCL_V9 && code != `DCC_NCL_V15 &&
            code != `DCC_NCL_V18;
    end
    return bad;
  endfunction : dcc_clamp_bad

  assign pins = {user_toggle, converter_power_good, dac_fault, overheat,
                 crc_error, watchdog_fault, learning_done, voltage_mode};

  assign idx = address[7:2];
  assign req = read | write;
  // One wait cycle: read data is registered before the answer
  assign waitrequest = req & ~st_ff.ack;
  assign commit = req & st_ff.ack;
  assign wr = commit & write;

  // Rising edges of synchronised event pins; power good on either edge
  always_comb begin
    events = '0;
    events[`DCC_IRQ_LEARN] = st_ff.sync2[`DCC_PIN_LEARN] &
                             ~st_ff.prev[`DCC_PIN_LEARN];
    events[`DCC_IRQ_WDT] = st_ff.sync2[`DCC_PIN_WDT] &
                           ~st_ff.prev[`DCC_PIN_WDT];
    events[`DCC_IRQ_CRC] = st_ff.sync2[`DCC_PIN_CRC] &
                           ~st_ff.prev[`DCC_PIN_CRC];
    events[`DCC_IRQ_TMP] = st_ff.sync2[`DCC_PIN_TMP] &
                           ~st_ff.prev[`DCC_PIN_TMP];
    events[`DCC_IRQ_FAULT] = st_ff.sync2[`DCC_PIN_FAULT] &
                             ~st_ff.prev[`DCC_PIN_FAULT];
    events[`DCC_IRQ_PG] = st_ff.sync2[`DCC_PIN_PG] ^
                          st_ff.prev[`DCC_PIN_PG];
    // Clamp event is raised in the next-state logic, not here
    events[`DCC_IRQ_BADCL] = 1'b0;
  end

  // Sticky status sets coming from hardware
  always_comb begin
    hw_set = '0;
    hw_set[`DCC_ST_LEARN] = events[`DCC_IRQ_LEARN]; // see [R10]
    hw_set[`DCC_ST_WDT] = events[`DCC_IRQ_WDT];
    hw_set[`DCC_ST_CRC] = events[`DCC_IRQ_CRC];
    hw_set[`DCC_ST_TMP] = events[`DCC_IRQ_TMP];
    hw_set[`DCC_ST_FAULT] = events[`DCC_IRQ_FAULT];
  end

  // Read mux, reserved bits and unmapped words read zero
  always_comb begin
    rd16 = 16'h0000;
    unique case (idx)
      `DCC_IDX_BB_CFG: rd16 = {10'h000, st_ff.bb_cfg};
      `DCC_IDX_CAL_EN: rd16 = {15'h0000, st_ff.cal_on}; // see [R6]
      `DCC_IDX_GAIN: rd16 = st_ff.gain; // see [R7]
      `DCC_IDX_OFFS: rd16 = st_ff.offs; // see [R8]
      `DCC_IDX_STATUS: rd16 = st_ff.status; // see [R9]
      `DCC_IDX_IRQ_STAT: rd16 = {9'h000, st_ff.irq_stat};
      `DCC_IDX_IRQ_EN: rd16 = {9'h000, st_ff.irq_en};
      default: rd16 = 16'h0000;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync1 = pins;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.prev = st_ff.sync2;
    nxt_st.ack = req & ~st_ff.ack;
    if (read && !st_ff.ack) begin
      nxt_st.rdata = {16'h0000, rd16};
    end

    if (wr) begin
      unique case (idx)
        `DCC_IDX_BB_CFG: begin
          // Invalid clamp codes are stored and flagged, not refused
          nxt_st.bb_cfg = 6'(dcc_merge({10'h000, st_ff.bb_cfg},
                                       writedata, byteenable));
        end
        `DCC_IDX_CAL_EN: begin
          if (byteenable[0]) begin
            nxt_st.cal_on = writedata[0]; // see [R6]
          end
        end
        `DCC_IDX_GAIN: begin
          nxt_st.gain = dcc_merge(st_ff.gain, writedata,
                                  byteenable); // see [R7]
        end
        `DCC_IDX_OFFS: begin
          nxt_st.offs = dcc_merge(st_ff.offs, writedata,
                                  byteenable); // see [R8]
        end
        `DCC_IDX_STATUS: begin
          nxt_st.status = dcc_merge(st_ff.status, writedata, byteenable) &
                          `DCC_STATUS_WMASK;
        end
        `DCC_IDX_IRQ_EN: begin
          if (byteenable[0]) begin
            nxt_st.irq_en = writedata[6:0];
          end
        end
        `DCC_IDX_IRQ_CLR: begin
          if (byteenable[0]) begin
            nxt_st.irq_stat = st_ff.irq_stat & ~writedata[6:0];
          end
        end
        default: begin
          nxt_st.ack = nxt_st.ack;
        end
      endcase
    end

    // Hardware set wins over a software write in the same cycle
    nxt_st.status = (nxt_st.status | hw_set) & `DCC_STATUS_WMASK;
    nxt_st.status[`DCC_ST_PG] = st_ff.sync2[`DCC_PIN_PG];
    nxt_st.status[`DCC_ST_TGL] = st_ff.sync2[`DCC_PIN_TGL];

    // Clamp decode follows the stored code and the output mode
    nxt_st.clamp_volts = dcc_clamp_volts(
      nxt_st.bb_cfg[`DCC_NCLAMP_HI:`DCC_NCLAMP_LO],
      st_ff.sync2[`DCC_PIN_VMODE]); // see [R1]
    nxt_st.clamp_bad = dcc_clamp_bad(
      nxt_st.bb_cfg[`DCC_NCLAMP_HI:`DCC_NCLAMP_LO],
      st_ff.sync2[`DCC_PIN_VMODE]); // see [R2]

    // A clamp that turns invalid is reported once
    nxt_st.irq_stat = nxt_st.irq_stat | events;
    if (nxt_st.clamp_bad && !st_ff.clamp_bad) begin
      nxt_st.irq_stat[`DCC_IRQ_BADCL] = 1'b1; // see [R2]
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
      st_ff.bb_cfg <= `DCC_BB_CFG_RST; // see [R1] see [R3]
      st_ff.status <= `DCC_STATUS_RST; // see [R9]
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ncl = st_ff.bb_cfg[`DCC_NCLAMP_HI:`DCC_NCLAMP_LO];
  assign arm = st_ff.bb_cfg[`DCC_ARM_HI:`DCC_ARM_LO];

  // Code 11 is undocumented, so both arms stay off for it too
  assign pos_arm_en = arm == `DCC_ARM_POS; // see [R3] see [R4]
  assign neg_arm_en = arm == `DCC_ARM_NEG; // see [R3] see [R5]
  assign negative_clamp_select = ncl;
  assign neg_clamp_volts = st_ff.clamp_volts;
  assign clamp_code_invalid = st_ff.clamp_bad;
  assign readdata = st_ff.rdata;
  assign irq = |(st_ff.irq_stat & st_ff.irq_en);

  dcc_cal u_cal (
    .clk(clk),
    .resetn(resetn),
    .cal_on(st_ff.cal_on),
    .gain(st_ff.gain),
    .offs(st_ff.offs),
    .code_in(code_in),
    .code_in_valid(code_in_valid),
    .code_out(code_out),
    .code_out_valid(code_out_valid)
  ); // see [R11]

endmodule : dcc_regs

// ===== dcc_regs_assertions.sv
/*
  Port checker for dcc_regs: bus timing, code echo, arms and clamp decode.
  Assumes it is bound to every dcc_regs instance by the bind below.
*/
`timescale 1ns/10ps

module dcc_regs_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  input wire logic code_in_valid,
  input wire logic code_out_valid,
  input wire logic pos_arm_en,
  input wire logic neg_arm_en,
  input wire logic [3:0] negative_clamp_select,
  input wire logic [4:0] neg_clamp_volts,
  input wire logic clamp_code_invalid
);
  localparam logic [0:9][4:0] VOLTS = {5'h05, 5'h06, 5'h09, 5'h0B, 5'h0C,
    5'h0D, 5'h0E, 5'h0F, 5'h12, 5'h12};

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  a_wait_one_cycle: assert property (
    (read || write) && waitrequest |=> !waitrequest)
    else $error("wait longer than one cycle");
  a_read_upper_zero: assert property (
    readdata[31:16] == 16'h0000)
    else $error("upper read lanes not zero");
  a_read_data_hold: assert property (
    !read |=> $stable(readdata))
    else $error("read data moved without a read");
  a_echo_valid: assert property (
    code_in_valid |=> code_out_valid)
    else $error("code not echoed");
  a_echo_idle: assert property (
    !code_in_valid |=> !code_out_valid)
    else $error("spurious code valid");
  a_arms_exclusive: assert property (
    !(pos_arm_en && neg_arm_en))
    else $error("both arms enabled");
  a_clamp_bad_zero: assert property (
    clamp_code_invalid |-> neg_clamp_volts == 5'h00)
    else $error("volts on bad clamp");
  a_clamp_volt_map: assert property (
    $past(resetn) && !clamp_code_invalid && $stable(negative_clamp_select)
    |-> neg_clamp_volts == VOLTS[negative_clamp_select])
    else $error("clamp volts wrong");
  a_clamp_high_bad: assert property (
    $past(resetn) && negative_clamp_select >= 4'hA
    && $stable(negative_clamp_select) |-> clamp_code_invalid)
    else $error("high clamp code accepted");

  c_clamp_bad: cover property (clamp_code_invalid);
  c_pos_arm: cover property (pos_arm_en);
  c_neg_arm: cover property (neg_arm_en);
  c_stream: cover property (code_in_valid && code_out_valid);
endmodule : dcc_regs_chk

bind dcc_regs dcc_regs_chk u_chk (.clk, .resetn, .read, .write,
  .waitrequest, .readdata, .code_in_valid, .code_out_valid, .pos_arm_en,
  .neg_arm_en, .negative_clamp_select, .neg_clamp_volts, .clamp_code_invalid);

// ===== dcc_regs_tb.sv
/*
  Self-checking bench for dcc_regs: registers, clamp decode, status, irq.
  Assumes dcc_regs_chk is bound to the design from its own file.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end

module dcc_regs_tb;
  logic clk, resetn, read, write, vmode, cvld, pg, tgl;
  logic wait_o, cvo, pos, neg, bad, irq;
  logic [7:0] address;
  logic [3:0] be, ncs;
  logic [31:0] wdata, rdata;
  logic [15:0] cin, cout, o;
  logic [4:0] ev;
  logic [4:0] volts;
  int n_errors = 0;
  int tests_run = 0;
  localparam logic [0:9][4:0] VOLTS = {5'h05, 5'h06, 5'h09, 5'h0B, 5'h0C,
    5'h0D, 5'h0E, 5'h0F, 5'h12, 5'h12};

  dcc_regs uut (.clk(clk), .resetn(resetn), .address(address), .read(read),
    .write(write), .byteenable(be), .writedata(wdata), .readdata(rdata),
    .waitrequest(wait_o), .voltage_mode(vmode), .learning_done(ev[4]),
    .watchdog_fault(ev[3]), .crc_error(ev[2]), .overheat(ev[1]),
    .dac_fault(ev[0]), .converter_power_good(pg), .user_toggle(tgl),
    .code_in(cin), .code_in_valid(cvld), .code_out(cout),
    .code_out_valid(cvo), .pos_arm_en(pos), .neg_arm_en(neg),
    .negative_clamp_select(ncs), .neg_clamp_volts(volts),
    .clamp_code_invalid(bad), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic print_verdict;
    if (n_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [5:0] i,
    input logic [15:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address <= {i, 2'b00};
    read <= !wr;
    write <= wr;
    wdata <= {16'h0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (wait_o !== 1'b0 && n < 40);
    if (wait_o !== 1'b0) n_errors++;
    q = rdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] i, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, i, d, q);
  endtask : wr

  task automatic rchk(input logic [5:0] i, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, i, 16'h0000, q);
    `CHK(q, e)
  endtask : rchk

  // Returns {invalid, volts}
  function automatic logic [5:0] clamp_exp(input logic [3:0] c,
    input logic vm);
    logic ok;
    ok = vm ? (c == 4'h2 || c == 4'h7 || c == 4'h9) : (c <= 4'h9);
    return ok ? {1'b0, VOLTS[c]} : 6'h20;
  endfunction : clamp_exp

  // Gain held at zero so only the signed offset and saturation apply
  function automatic logic [15:0] cal_exp(input logic [15:0] x,
    input logic on, input logic [15:0] ofs);
    int s;
    s = int'(x) + int'($signed(ofs));
    if (!on) return x;
    return s < 0 ? 16'h0000 : (s > 65535 ? 16'hFFFF : 16'(s));
  endfunction : cal_exp

  task automatic stream(input logic on, input logic [15:0] ofs);
    logic [15:0] c, p;
    for (int i = 0; i <= 20; i++) begin
      c = i == 0 ? 16'hFFFF : (i == 1 ? 16'h0000 : 16'($urandom));
      @(posedge clk);
      cin <= c;
      cvld <= (i < 20);
      @(negedge clk);
      if (i > 0) `CHK({cvo, cout}, {1'b1, cal_exp(p, on, ofs)})
      p = c;
    end
    @(negedge clk);
    `CHK(cvo, 1'b0)
  endtask : stream

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict();
  end

  initial begin
    {resetn, read, write, vmode, cvld, pg, tgl} = 7'h00;
    ev = 5'h00;
    cin = 16'h0000;
    be = 4'hF;
    address = 8'h00;
    wdata = 32'h0;
    void'($urandom(84439));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rchk(6'h07, 32'h0);
    `CHK({pos, neg}, 2'b00)
    rchk(6'h08, 32'h0);
    rchk(6'h09, 32'h0);
    rchk(6'h0A, 32'h0);
    rchk(6'h0B, 32'h1000);
    rchk(6'h3F, 32'h0);
    wr(6'h08, 16'hFFFF);
    rchk(6'h08, 32'h1);
    o = 16'($urandom);
    wr(6'h09, o);
    rchk(6'h09, {16'h0000, o});
    // Low lane only: the high byte keeps its value
    be <= 4'h1;
    wr(6'h09, 16'h0000);
    rchk(6'h09, {16'h0000, o[15:8], 8'h00});
    be <= 4'hF;
    wr(6'h09, 16'h0000);
    o = 16'($urandom);
    wr(6'h0A, o);
    rchk(6'h0A, {16'h0000, o});
    stream(1'b1, o);
    wr(6'h08, 16'h0000);
    stream(1'b0, o);
    for (int m = 0; m < 2; m++) begin
      vmode <= m[0];
      for (int c = 0; c < 16; c++) begin
        wr(6'h07, {10'h000, c[3:0], c[1:0]});
        repeat (4) @(posedge clk);
        rchk(6'h07, {26'h0, c[3:0], c[1:0]});
        `CHK({bad, volts, ncs}, {clamp_exp(c[3:0], m[0]), c[3:0]})
        `CHK({pos, neg}, {c[1:0] == 2'h1, c[1:0] == 2'h2})
      end
    end
    rchk(6'h10, 32'h40);
    wr(6'h11, 16'h0000);
    wr(6'h12, 16'h007F);
    wr(6'h0B, 16'h0000);
    rchk(6'h0B, 32'h0);
    @(posedge clk);
    ev <= 5'h1F;
    pg <= 1'b1;
    tgl <= 1'b1;
    repeat (4) @(posedge clk);
    ev <= 5'h00;
    repeat (4) @(posedge clk);
    rchk(6'h0B, 32'h18F1);
    rchk(6'h10, 32'h3F);
    `CHK(irq, 1'b0)
    wr(6'h11, 16'h007F);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    wr(6'h12, 16'h007F);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    pg <= 1'b0;
    tgl <= 1'b0;
    repeat (4) @(posedge clk);
    // Power-good falling edge raises the interrupt again
    `CHK(irq, 1'b1)
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rchk(6'h0B, 32'h1000);
    rchk(6'h07, 32'h0);
    print_verdict();
  end
endmodule : dcc_regs_tb
